// ==== test/sar_host_model.sv ====
// Host controller model on the two-wire register link.
// Assumes a bench-resolved pull-up on data; steps on falling core clock edges.
`timescale 1ns/1ns
module sar_host_model
  import sar_pkg::*;
#(
  parameter logic [6:0] ADDR = SLAVE_ADDR_DEFAULT
) (
  input wire logic i_clk, // Time base.
  input wire logic i_sda, // Resolved data wire.
  output logic o_scl, // Link clock, high when idle.
  output logic o_sda_low // High while the host pulls data low.
);
  // Each waveform step lasts six core clocks; between bits the link clock stays low for two steps.
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic half();
    repeat (6) @(negedge i_clk);
  endtask
  // Data set while the clock is low, sampled as the clock falls.
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    half();
    o_scl = 1'b1;
    half();
    r = i_sda;
    o_scl = 1'b0;
    half();
  endtask
  task automatic start();
    o_sda_low = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda_low = 1'b1;
    half();
    o_scl = 1'b0;
    half();
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda_low = 1'b0;
    half();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    wr_byte({ADDR, 1'b0}, k0);
    wr_byte(a, k1);
    wr_byte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  // Pointer write, repeated start, one byte read and closed with a refusal.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2, r;
    start();
    wr_byte({ADDR, 1'b0}, k0);
    wr_byte(a, k1);
    start();
    wr_byte({ADDR, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(1'b1, r);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule

// ==== test/sar_top_props.sv ====
// Concurrent checks on the ports of the sensor result and pad register bank.
// Assumes one core clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module sar_top_props (
  input wire logic i_core_clk, // Core clock.
  input wire logic i_rst, // Reset, active high.
  input wire logic i_scl, // Link clock pin.
  input wire logic o_sda_out, // Data drive value.
  input wire logic o_sda_oe, // Data drive enable.
  input wire logic [1:0] o_pad_out, // Pad drive values.
  input wire logic [1:0] o_pad_oe, // Pad drive enables.
  input wire logic o_osc_on, // Oscillator enable.
  input wire logic [1:0] o_converter_bias, // Converter bias.
  input wire logic [1:0] o_amplifier_bias, // Amplifier bias.
  input wire logic [3:0] o_stage_enable // Stage enables.
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  // Values at the first edge after reset is released.
  osc_reset_a: assert property ($fell(i_rst) |-> o_osc_on)
    else $error("oscillator enable low after reset");
  pad_dir_reset_a: assert property ($fell(i_rst) |-> o_pad_oe == 2'h3)
    else $error("pad enables wrong after reset");
  pad_drive_reset_a: assert property ($fell(i_rst) |-> o_pad_out == 2'h0)
    else $error("pad drive values wrong after reset");
  bias_reset_a: assert property ($fell(i_rst) |-> o_converter_bias == 2'h3 && o_amplifier_bias == 2'h3)
    else $error("bias selects wrong after reset");
  stage_reset_a: assert property ($fell(i_rst) |-> o_stage_enable == 4'h0)
    else $error("stage enables wrong after reset");
  ////////////////////////////////////////////////////////////////////////////
  // Register outputs move only just after a link clock rise.
  write_timing_a: assert property ($changed({o_osc_on, o_pad_out, o_pad_oe, o_converter_bias, o_amplifier_bias,
    o_stage_enable}) |-> $past(i_scl))
    else $error("register output moved without a link write");
  // Data is only pulled low, and the pull starts and ends only while the link clock is low.
  sda_open_drain_a: assert property (o_sda_oe |-> o_sda_out == 1'b0)
    else $error("data line driven high");
  sda_launch_a: assert property ($rose(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("data drive started with clock high");
  sda_release_a: assert property ($fell(o_sda_oe) |-> !i_scl)
    else $error("data drive released with clock high");
  cover property ($rose(o_sda_oe));
  cover property ($changed(o_stage_enable));
  cover property ($fell(o_pad_oe[0]));
endmodule

bind sar_top sar_top_props u_props (.*);

// ==== test/tb_top.sv ====
// Self-checking bench for the register bank, driven through the host model.
// Assumes the package and checker are compiled first.
`timescale 1ns/1ns
module tb_top;
  import sar_pkg::*;
  localparam logic [15:0] PORTS_RST = {3'h0, 1'h1, 2'h0, 2'h3, 2'h3, 2'h3, 4'h0};
  logic i_core_clk, i_rst, i_ce, i_conv_valid, i_conv_busy, i_scl, host_low, o_sda_out, o_sda_oe, o_osc_on;
  logic signed [17:0] i_conv_raw;
  logic [1:0] i_pad_in, o_pad_out, o_pad_oe, o_converter_bias, o_amplifier_bias;
  logic [3:0] o_stage_enable;
  wire i_sda = !(host_low || (o_sda_oe && !o_sda_out));
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  sar_top u_dut (.*);
  sar_host_model u_host (.i_clk(i_core_clk), .i_sda, .o_scl(i_scl),
    .o_sda_low(host_low));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard.
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [15:0] ports();
    return {3'h0, o_osc_on, o_pad_out, o_pad_oe, o_converter_bias, o_amplifier_bias, o_stage_enable};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.write_reg(a, d, ok);
    check({15'h0, ok}, 16'h0001);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    logic ok;
    u_host.read_reg(a, v, ok);
    check({7'h00, ok, v}, {8'h01, exp});
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset_values();
    logic [7:0] adr [12] = '{ADDR_OSC, ADDR_PAD_OUT, ADDR_RES_LO, ADDR_RES_HI, ADDR_CFG0, ADDR_CFG1, ADDR_CFG2,
      ADDR_CFG3, ADDR_CFG4, ADDR_CFG5, ADDR_MODE, 8'h20};
    logic [7:0] val [12] = '{RST_OSC, RST_PAD_OUT, RST_RESULT[7:0], RST_RESULT[15:8], RST_CFG0, RST_CFG1,
      RST_CFG2, RST_CFG3, RST_CFG4, RST_CFG5, RST_MODE, 8'h00};
    check(ports(), PORTS_RST);
    for (int i = 0; i < 12; i++) begin
      rd(adr[i], val[i]);
    end
  endtask
  task automatic t_osc();
    wr(ADDR_OSC, 8'hFE);
    check({15'h0, o_osc_on}, 16'h0000);
    rd(ADDR_OSC, 8'h00);
    wr(ADDR_OSC, 8'hFF);
    check({15'h0, o_osc_on}, 16'h0001);
    rd(ADDR_OSC, 8'h01);
  endtask
  // Direction and reference options gate pad enables.
  task automatic t_pads();
    logic [7:0] p [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h12, 8'h21};
    logic [7:0] m [5] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00};
    logic [3:0] e [5] = '{4'hF, 4'hD, 4'hE, 4'h9, 4'h6};
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_PAD_OUT, p[i]);
      wr(ADDR_MODE, m[i]);
      check({12'h0, o_pad_out, o_pad_oe}, {12'h0, e[i]});
      rd(ADDR_PAD_OUT, p[i] & MSK_PAD_OUT);
    end
  endtask
  task automatic t_pad_in();
    for (int v = 0; v < 4; v++) begin
      i_pad_in = 2'(v);
      rd(ADDR_PAD_IN, 8'(v));
    end
  endtask
  // Sampling rate stays at reset, inside every bias limit.
  task automatic t_bias();
    logic [1:0] c [3] = '{2'h0, 2'h1, 2'h3};
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CFG1, {c[i], c[2 - i], 4'hF});
      check({8'h0, o_converter_bias, o_amplifier_bias, o_stage_enable}, {8'h0, c[i], c[2 - i], 4'hF});
    end
    wr(ADDR_CFG1, 8'hF0);
    check({8'h0, o_converter_bias, o_amplifier_bias, o_stage_enable}, 16'h00F0);
  endtask
  // Saturation, forced low bits and the sixteen-bit cap.
  task automatic t_result();
    logic [7:0] c [6] = '{8'h28, 8'h28, 8'h00, 8'h4C, 8'h14, 8'h7C};
    logic [17:0] r [6] = '{18'h08000, 18'h37FFF, 18'h01234, 18'h3FFFF, 18'h01235, 18'h38000};
    logic [15:0] e [6] = '{16'h7FFF, 16'h8000, 16'h1200, 16'hFFFE, 16'h1235, 16'h8000};
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CFG0, c[i]);
      i_conv_raw = r[i];
      i_conv_valid = 1'b1;
      @(negedge i_core_clk);
      i_conv_valid = 1'b0;
      rd(ADDR_RES_LO, e[i][7:0]);
      rd(ADDR_RES_HI, e[i][15:8]);
    end
  endtask
  task automatic t_second_reset();
    wr(ADDR_OSC, 8'h00);
    i_rst = 1'b1;
    repeat (3) @(negedge i_core_clk);
    i_rst = 1'b0;
    repeat (5) @(negedge i_core_clk);
    check(ports(), PORTS_RST);
    rd(ADDR_PAD_OUT, RST_PAD_OUT);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_conv_raw = 18'h00000;
    i_conv_valid = 1'b0;
    i_conv_busy = 1'b0;
    i_pad_in = 2'h0;
    repeat (20) @(negedge i_core_clk);
    i_rst = 1'b0;
    repeat (5) @(negedge i_core_clk);
    t_reset_values();
    t_osc();
    t_pads();
    t_pad_in();
    t_bias();
    t_result();
    t_second_reset();
    give_verdict();
  end
endmodule

// ==== verilog/sar_core_if.sv ====
// Interface between the register core, the result formatter and the pad logic.
// Assumes all three share the core clock.
`timescale 1ns/1ns
interface sar_core_if;
  logic signed [17:0] raw_code; // Converter output before formatting.
  logic [2:0] osr_code; // Oversampling ratio code.
  logic [1:0] nelc_code; // Elementary count code.
  logic [15:0] fmt_code; // Saturated and formatted result.
  logic [1:0] pad_dir; // Pad directions, 1 is output.
  logic ext_ref_one; // Pad one used as reference input.
  logic ref_out_zero; // Pad zero used as reference output.
  logic [1:0] pad_raw; // Pad levels straight from the pins.
  logic [1:0] pad_oe; // Pad drive enables.
  logic [1:0] pad_level; // Synchronised pad levels.

  modport fmt (input raw_code, osr_code, nelc_code, output fmt_code);
  modport pad (input pad_dir, ext_ref_one, ref_out_zero, pad_raw, output pad_oe, pad_level);
  modport core (output raw_code, osr_code, nelc_code, pad_dir, ext_ref_one, ref_out_zero, pad_raw,
                input fmt_code, pad_oe, pad_level);
endinterface

// ==== verilog/sar_pad_ctrl.sv ====
// Pad drive enables and the two-stage synchroniser for the pad levels.
// Assumes the pads are asynchronous to the core clock.
`timescale 1ns/1ns
module sar_pad_ctrl
  import sar_pkg::*;
(
  input wire logic i_core_clk, // Core clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic i_ce, // Clock enable.
  sar_core_if.pad bus // Pad settings in, enables and levels out.
);

  logic [1:0] sync1_reg;
  logic [1:0] sync1_next;
  logic [1:0] sync2_reg;
  logic [1:0] sync2_next;

  // Next values of the synchroniser stages.
  always_comb begin
    sync1_next = sync1_reg;
    sync2_next = sync2_reg;
    if (i_ce) begin
      sync1_next = bus.pad_raw;
      sync2_next = sync1_reg;
    end
  end

  // Synchroniser flip-flops.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // Live level of each pad.
  assign bus.pad_level = sync2_reg; // RL14

  // A pad drives only as an output and while its reference option is off.
  assign bus.pad_oe[1] = bus.pad_dir[1] & ~bus.ext_ref_one; // RL12
  assign bus.pad_oe[0] = bus.pad_dir[0] & ~bus.ref_out_zero; // RL13
endmodule

// ==== verilog/sar_pkg.sv ====
// Shared constants and types for the sensor result and pad register bank.
// Assumes a single core clock and one serial register link from the host.
package sar_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses on the serial link.
  localparam logic [7:0] ADDR_OSC = 8'h30;
  localparam logic [7:0] ADDR_PAD_OUT = 8'h40;
  localparam logic [7:0] ADDR_PAD_IN = 8'h41;
  localparam logic [7:0] ADDR_RES_LO = 8'h50;
  localparam logic [7:0] ADDR_RES_HI = 8'h51;
  localparam logic [7:0] ADDR_CFG0 = 8'h52;
  localparam logic [7:0] ADDR_CFG1 = 8'h53;
  localparam logic [7:0] ADDR_CFG2 = 8'h54;
  localparam logic [7:0] ADDR_CFG3 = 8'h55;
  localparam logic [7:0] ADDR_CFG4 = 8'h56;
  localparam logic [7:0] ADDR_CFG5 = 8'h57;
  localparam logic [7:0] ADDR_MODE = 8'h70;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values after power-on.
  localparam logic [7:0] RST_OSC = 8'h01;
  localparam logic [7:0] RST_PAD_OUT = 8'h30;
  localparam logic [7:0] RST_CFG0 = 8'h28;
  localparam logic [7:0] RST_CFG1 = 8'hF0;
  localparam logic [7:0] RST_CFG2 = 8'h00;
  localparam logic [7:0] RST_CFG3 = 8'h0C;
  localparam logic [7:0] RST_CFG4 = 8'h00;
  localparam logic [7:0] RST_CFG5 = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h04;
  localparam logic [15:0] RST_RESULT = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Writable bit masks; bits outside a mask are never stored and read zero, except CFG5 bit 7, which reads the converter busy input.
  localparam logic [7:0] MSK_OSC = 8'h01;
  localparam logic [7:0] MSK_PAD_OUT = 8'h33;
  localparam logic [7:0] MSK_CFG0 = 8'hFE;
  localparam logic [7:0] MSK_CFG1 = 8'hFF;
  localparam logic [7:0] MSK_CFG2 = 8'hFF;
  localparam logic [7:0] MSK_CFG3 = 8'hFF;
  localparam logic [7:0] MSK_CFG4 = 8'h7F;
  localparam logic [7:0] MSK_CFG5 = 8'h7F;
  localparam logic [7:0] MSK_MODE = 8'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int OSC_ON_BIT = 0;
  localparam int PAD1_DIR_BIT = 5;
  localparam int PAD0_DIR_BIT = 4;
  localparam int PAD1_DRV_BIT = 1;
  localparam int PAD0_DRV_BIT = 0;
  localparam int CBIAS_HI = 7;
  localparam int CBIAS_LO = 6;
  localparam int ABIAS_HI = 5;
  localparam int ABIAS_LO = 4;
  localparam int ENABLE_HI = 3;
  localparam int NELC_HI = 6;
  localparam int NELC_LO = 5;
  localparam int OSR_HI = 4;
  localparam int OSR_LO = 2;
  localparam int BUSY_BIT = 7;
  localparam int MODE_REF_OUT_ZERO_BIT = 1;
  localparam int MODE_EXT_REF_ONE_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Result format.
  localparam int RAW_WIDTH = 18;
  localparam int RES_WIDTH = 16;
  localparam logic [4:0] RES_FULL_BITS = 5'd16;
  localparam logic [4:0] RES_BASE_BITS = 5'd6;
  localparam logic [15:0] RES_MAX = 16'h7FFF;
  localparam logic [15:0] RES_MIN = 16'h8000;

  // Link slave address; the value is arbitrary.
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h48;

  // Serial link byte engine states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK_WAIT,
    ST_ACK,
    ST_TX,
    ST_TACK
  } sar_link_state_t;

endpackage

// ==== verilog/sar_result_fmt.sv ====
// Saturates the converter output to 16 bits and forces insignificant low bits.
// Assumes a signed raw code wider than the result, on the core clock.
`timescale 1ns/1ns
module sar_result_fmt
  import sar_pkg::*;
(
  sar_core_if.fmt bus // Raw code and settings in, formatted code out.
);

  logic [4:0] res_bits;
  logic [4:0] force_cnt;
  logic over_pos;
  logic over_neg;
  logic [15:0] forced;

  // Resolution is twice log2 of the ratio plus log2 of the count, capped at 16.
  always_comb begin
    res_bits = RES_BASE_BITS + {1'b0, bus.osr_code, 1'b0} + {3'b000, bus.nelc_code}; // RL4
    if (res_bits > RES_FULL_BITS) begin
      res_bits = RES_FULL_BITS; // RL4
    end
    force_cnt = RES_FULL_BITS - res_bits;
  end

  // Out-of-range codes clamp to the nearest extreme instead of wrapping.
  assign over_pos = (bus.raw_code > $signed({2'b00, RES_MAX})); // RL2
  assign over_neg = (bus.raw_code < $signed({2'b11, RES_MIN})); // RL2

  // Each bit below the resolution becomes a one on top of zeros.
  genvar gi;
  generate
    for (gi = 0; gi < RES_WIDTH; gi++) begin : g_force
      always_comb begin
        if ((gi + 1) == force_cnt) begin
          forced[gi] = 1'b1; // RL3
        end else if ((gi + 1) < force_cnt) begin
          forced[gi] = 1'b0; // RL3
        end else begin
          forced[gi] = bus.raw_code[gi];
        end
      end
    end
  endgenerate

  // Two's complement 16-bit code.
  assign bus.fmt_code = over_pos ? RES_MAX : (over_neg ? RES_MIN : forced); // RL1
endmodule

// ==== verilog/sar_top.sv ====
// Register bank of the sensor acquisition chip behind a two-wire serial slave.
// Assumes the link pins are asynchronous and the converter runs on the core clock.
`timescale 1ns/1ns

// How it works
// [RL1] Results are sixteen-bit two's complement, split into low and high bytes.
// [RL2] Out-of-range inputs clamp to 7FFF or 8000, never wrap.
// [RL3] Below sixteen bits the low bits read as one then zeros.
// [RL4] Resolution is twice log2 ratio plus log2 count, capped at sixteen.
// [RL5] Converter bias sits at bits 7:6, amplifier bias at 5:4.
// [RL6] Host keeps sampling rate within each bias setting's limit.
// [RL7] Amplifier and converter stages can be switched off when idle.
// [RL8] Unused bits ignore writes and have no effect.
// [RL9] Every field takes its reset value at power-on reset.
// [RL10] Bit 0 at 0x30 enables the oscillator, resets to one.
// [RL11] Bits 5 and 4 at 0x40 set pad directions, reset to output.
// [RL12] Bit 1 drives pad one when output and no external reference.
// [RL13] Bit 0 drives pad zero when output and no reference output.
// [RL14] Address 0x41 returns live pad levels on bits 1:0.
// [RL15] Result low byte at 0x50, high byte at 0x51.
module sar_top
  import sar_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEFAULT
) (
  input wire logic i_core_clk, // Core clock, 20 MHz.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic i_ce, // Clock enable; low freezes all state.
  input wire logic i_scl, // Serial link clock pin.
  input wire logic i_sda, // Serial link data pin level.
  output logic o_sda_out, // Serial data drive value, always low.
  output logic o_sda_oe, // Serial data drive enable.
  input wire logic signed [17:0] i_conv_raw, // Converter raw code.
  input wire logic i_conv_valid, // Raw code valid pulse.
  input wire logic i_conv_busy, // Converter activity.
  input wire logic [1:0] i_pad_in, // Pad pin levels.
  output logic [1:0] o_pad_out, // Pad drive values.
  output logic [1:0] o_pad_oe, // Pad drive enables.
  output logic o_osc_on, // Oscillator enable.
  output logic [1:0] o_converter_bias, // Converter bias select.
  output logic [1:0] o_amplifier_bias, // Amplifier bias select.
  output logic [3:0] o_stage_enable // Amplifier and converter stage enables.
);

  sar_core_if core_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Link pin synchronisers; the third stage only feeds edge detection.

  logic [2:0] scl_reg;
  logic [2:0] scl_next;
  logic [2:0] sda_reg;
  logic [2:0] sda_next;

  // Next values of the pin stages.
  always_comb begin
    scl_next = scl_reg;
    sda_next = sda_reg;
    if (i_ce) begin
      scl_next = {scl_reg[1:0], i_scl};
      sda_next = {sda_reg[1:0], i_sda};
    end
  end

  // Pin stage flip-flops; an idle bus reads high.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_reg <= 3'h7;
      sda_reg <= 3'h7;
    end else begin
      scl_reg <= scl_next;
      sda_reg <= sda_next;
    end
  end

  logic scl_s;
  logic scl_d;
  logic sda_s;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Edge and framing detection on the synchronised pins.
  assign scl_s = scl_reg[1];
  assign scl_d = scl_reg[2];
  assign sda_s = sda_reg[1];
  assign sda_d = sda_reg[2];
  assign scl_rise = i_ce & scl_s & ~scl_d;
  assign scl_fall = i_ce & ~scl_s & scl_d;
  assign bus_start = i_ce & scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = i_ce & scl_s & scl_d & ~sda_d & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0] osc_reg;
  logic [7:0] osc_next;
  logic [7:0] pad_out_reg;
  logic [7:0] pad_out_next;
  logic [7:0] cfg_reg [0:5];
  logic [7:0] cfg_next [0:5];
  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;

  localparam logic [7:0] CFG_RST [0:5] = '{RST_CFG0, RST_CFG1, RST_CFG2, RST_CFG3, RST_CFG4, RST_CFG5};
  localparam logic [7:0] CFG_MSK [0:5] = '{MSK_CFG0, MSK_CFG1, MSK_CFG2, MSK_CFG3, MSK_CFG4, MSK_CFG5};

  // Next register values; unused bits are masked off on every write.
  always_comb begin
    osc_next = osc_reg;
    pad_out_next = pad_out_reg;
    mode_next = mode_reg;
    result_next = result_reg;
    for (int i = 0; i < 6; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    if (i_ce) begin
      if (wr_en) begin
        unique case (wr_addr)
          ADDR_OSC: osc_next = wr_data & MSK_OSC; // RL10 RL8
          ADDR_PAD_OUT: pad_out_next = wr_data & MSK_PAD_OUT; // RL11 RL8
          ADDR_CFG0: cfg_next[0] = wr_data & CFG_MSK[0]; // RL8
          ADDR_CFG1: cfg_next[1] = wr_data & CFG_MSK[1]; // RL5 RL8
          ADDR_CFG2: cfg_next[2] = wr_data & CFG_MSK[2];
          ADDR_CFG3: cfg_next[3] = wr_data & CFG_MSK[3];
          ADDR_CFG4: cfg_next[4] = wr_data & CFG_MSK[4]; // RL8
          ADDR_CFG5: cfg_next[5] = wr_data & CFG_MSK[5]; // RL8
          ADDR_MODE: mode_next = wr_data & MSK_MODE; // RL8
          default: ;
        endcase
      end
      if (i_conv_valid) begin
        result_next = core_bus.fmt_code; // RL1
      end
    end
  end

  // Register flip-flops with their power-on values.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      osc_reg <= RST_OSC; // RL9 RL10
      pad_out_reg <= RST_PAD_OUT; // RL9 RL11
      mode_reg <= RST_MODE; // RL9
      result_reg <= RST_RESULT; // RL9
      for (int i = 0; i < 6; i++) begin
        cfg_reg[i] <= CFG_RST[i]; // RL9
      end
    end else begin
      osc_reg <= osc_next;
      pad_out_reg <= pad_out_next;
      mode_reg <= mode_next;
      result_reg <= result_next;
      for (int i = 0; i < 6; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
    end
  end

  // Read data for the current pointer; unmapped addresses read zero.
  always_comb begin
    rd_byte = 8'h00;
    unique case (ptr_reg)
      ADDR_OSC: rd_byte = osc_reg; // RL10
      ADDR_PAD_OUT: rd_byte = pad_out_reg;
      ADDR_PAD_IN: rd_byte = {6'h00, core_bus.pad_level}; // RL14
      ADDR_RES_LO: rd_byte = result_reg[7:0]; // RL15
      ADDR_RES_HI: rd_byte = result_reg[15:8]; // RL15
      ADDR_CFG0: rd_byte = cfg_reg[0];
      ADDR_CFG1: rd_byte = cfg_reg[1];
      ADDR_CFG2: rd_byte = cfg_reg[2];
      ADDR_CFG3: rd_byte = cfg_reg[3];
      ADDR_CFG4: rd_byte = cfg_reg[4];
      ADDR_CFG5: rd_byte = cfg_reg[5] | {i_conv_busy, 7'h00};
      ADDR_MODE: rd_byte = mode_reg;
      default: rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial link byte engine.

  sar_link_state_t st_reg;
  sar_link_state_t st_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [1:0] idx_reg;
  logic [1:0] idx_next;
  logic rd_reg;
  logic rd_next;
  logic oe_reg;
  logic oe_next;
  logic [7:0] byte_in;

  assign byte_in = {sh_reg[6:0], sda_s};

  // Bits are sampled on rising link clock edges and driven after falling ones.
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    idx_next = idx_reg;
    rd_next = rd_reg;
    oe_next = oe_reg;
    wr_en = 1'b0;
    wr_addr = ptr_reg;
    wr_data = byte_in;
    if (bus_stop) begin
      st_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (bus_start) begin
      st_next = ST_RX;
      cnt_next = 4'h0;
      idx_next = 2'h0;
      oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: ;
        ST_RX: begin
          if (scl_rise) begin
            sh_next = byte_in;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == 4'h7) begin
              st_next = ST_ACK_WAIT;
              idx_next = (idx_reg == 2'h2) ? 2'h2 : idx_reg + 2'h1;
              if (idx_reg == 2'h0) begin
                rd_next = byte_in[0];
                if (byte_in[7:1] != SLAVE_ADDR) begin
                  st_next = ST_IDLE;
                end
              end else if (idx_reg == 2'h1) begin
                ptr_next = byte_in;
              end else begin
                wr_en = 1'b1;
                ptr_next = ptr_reg + 8'h01;
              end
            end
          end
        end
        ST_ACK_WAIT: begin
          if (scl_fall) begin
            oe_next = 1'b1;
            st_next = ST_ACK;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_next = 4'h0;
            if (rd_reg) begin
              sh_next = rd_byte;
              oe_next = ~rd_byte[7];
              st_next = ST_TX;
            end else begin
              oe_next = 1'b0;
              st_next = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (cnt_reg == 4'h8) begin
              oe_next = 1'b0;
              st_next = ST_TACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_reg[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            if (!sda_s) begin
              ptr_next = ptr_reg + 8'h01;
              st_next = ST_ACK;
            end else begin
              st_next = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Link engine flip-flops.
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      idx_reg <= 2'h0;
      rd_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (i_ce) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      idx_reg <= idx_next;
      rd_reg <= rd_next;
      oe_reg <= oe_next;
    end
  end

  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Result formatting and pad logic.

  assign core_bus.raw_code = i_conv_raw;
  assign core_bus.osr_code = cfg_reg[0][OSR_HI:OSR_LO];
  assign core_bus.nelc_code = cfg_reg[0][NELC_HI:NELC_LO];
  assign core_bus.pad_dir = {pad_out_reg[PAD1_DIR_BIT], pad_out_reg[PAD0_DIR_BIT]}; // RL11
  assign core_bus.ext_ref_one = mode_reg[MODE_EXT_REF_ONE_BIT];
  assign core_bus.ref_out_zero = mode_reg[MODE_REF_OUT_ZERO_BIT];
  assign core_bus.pad_raw = i_pad_in;

  sar_result_fmt u_fmt (
    .bus(core_bus)
  );

  sar_pad_ctrl u_pad (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .bus(core_bus)
  );

  // Outputs steered by the written registers.
  assign o_pad_out = {pad_out_reg[PAD1_DRV_BIT], pad_out_reg[PAD0_DRV_BIT]}; // RL12 RL13
  assign o_pad_oe = core_bus.pad_oe; // RL12 RL13
  assign o_osc_on = osc_reg[OSC_ON_BIT]; // RL10
  assign o_converter_bias = cfg_reg[1][CBIAS_HI:CBIAS_LO]; // RL5
  assign o_amplifier_bias = cfg_reg[1][ABIAS_HI:ABIAS_LO]; // RL5
  assign o_stage_enable = cfg_reg[1][ENABLE_HI:0]; // RL7
endmodule
